// >>> rtl/fbs_top.sv
// fbs_top: fieldbus slave instruction handshake, resets, comm-loss trip
// and link status lamps; remote words arrive already refreshed on clk
// What this block does
// - Code 74h returns the two latest fault records in the read data word.
// - On finishing, present read data and reply code, raise completion.
// - Error reset request acts only while a drive fault is present.
// - Reset select zero: link reset accepted in any operation mode.
// - In network mode, code FDh with key 9696h resets the drive.
// - Under fieldbus control, run commands come only from the master.
// - In network mode, trip on comm loss when exchange stops longer than the wait time.
// - Master reset or power-off stops exchange and trips comm loss too.
// - Link-run lamp on at good refresh, off after a silent period.
// - Link-error lamp on at local error, flashing on setting change.
// - New station or baud setting takes effect only after a reset.
// - Run lamp lit normally, flashing when master is old version.
// - Transmit lamp off whenever nothing is transmitted.
// - Receive lamp on while a receive carrier is detected.
// - Reply code zero means normal completion, nonzero means error.
`timescale 1ns/1ps
`default_nettype none
module fbs_top #(
    parameter int unsigned MS_CYCLES = fbs_pkg::MS_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic instr_exec_request,
    input wire logic [15:0] instr_code_word,
    input wire logic [15:0] write_data_word,
    input wire logic error_reset_request,
    input wire logic drive_fault,
    input wire logic fault_event,
    input wire logic [7:0] fault_code,
    input wire logic net_mode,
    input wire logic [15:0] comm_reset_select,
    input wire logic [15:0] comm_error_wait_time,
    input wire logic link_exchange,
    input wire logic refresh_ok,
    input wire logic local_comm_error,
    input wire logic [7:0] station_number_setting,
    input wire logic [2:0] baud_rate_setting,
    input wire logic master_ver1,
    input wire logic tx_active,
    input wire logic rx_carrier,
    input wire logic [1:0] link_run_cmd,
    input wire logic [1:0] panel_run_cmd,
    output logic instr_exec_done,
    output logic [15:0] reply_code_word,
    output logic [15:0] read_data_word,
    output logic drive_reset,
    output logic [1:0] run_cmd,
    output logic comm_loss_fault,
    output logic [7:0] active_station,
    output logic [2:0] active_baud,
    output logic link_run_lamp,
    output logic link_error_lamp,
    output logic run_lamp,
    output logic transmit_lamp,
    output logic receive_lamp
);

    typedef struct packed {
        fbs_pkg::fbs_state_t st;
        logic done;
        logic [15:0] reply;
        logic [15:0] rdata;
        logic drv_reset;
        logic [1:0] run_cmd;
        logic fault;
        logic [16:0] div;
        logic ms;
        logic [15:0] silent_ms;
        logic [15:0] lamp_ms;
        logic [7:0] blink_ms;
        logic blink;
        logic lrun;
        logic lerr;
        logic run_l;
        logic sd;
        logic rd;
        logic [2:0] rx_sync;
        logic err_rst_d;
        logic [7:0] station;
        logic [2:0] baud;
        logic loaded;
    } fbs_regs_t;

    fbs_regs_t r;
    fbs_regs_t next_r;
    logic [15:0] hist;
    logic start;
    logic link_reset_ok;
    logic err_rst_rise;
    logic pending;

    // fault records live in their own small store
    fbs_fault_hist u_hist (
        .clk(clk),
        .rstn(rstn),
        .fault_push(fault_event),
        .fault_code(fault_code),
        .hist(hist)
    );

    // a new instruction starts only with request high and completion low
    assign start = (r.st == fbs_pkg::FBS_IDLE) && instr_exec_request
        && !r.done;
    assign link_reset_ok = net_mode
        || (comm_reset_select == fbs_pkg::COMM_RESET_ANY_MODE);
    assign err_rst_rise = error_reset_request && !r.err_rst_d;
    // the running setting differs from what the switches now hold
    assign pending = r.loaded && ((station_number_setting != r.station)
        || (baud_rate_setting != r.baud));

    always_comb begin
        next_r = r;
        next_r.drv_reset = 1'b0;
        next_r.ms = 1'b0;
        next_r.err_rst_d = error_reset_request;

        // instruction handshake
        unique case (r.st)
            fbs_pkg::FBS_IDLE: begin
                if (start) begin
                    next_r.st = fbs_pkg::FBS_DONE;
                    next_r.done = 1'b1;
                    next_r.rdata = 16'h0000;
                    if (instr_code_word == fbs_pkg::CODE_FAULT_READ) begin
                        next_r.rdata = hist;
                        next_r.reply = fbs_pkg::REPLY_OK;
                    end else if (instr_code_word
                        == fbs_pkg::CODE_LINK_RESET) begin
                        // wrong key or disallowed mode answers an error
                        if (write_data_word == fbs_pkg::RESET_KEY
                            && link_reset_ok) begin
                            next_r.drv_reset = 1'b1;
                            next_r.reply = fbs_pkg::REPLY_OK;
                        end else begin
                            next_r.reply = fbs_pkg::REPLY_BAD_DATA;
                        end
                    end else begin
                        next_r.reply = fbs_pkg::REPLY_BAD_CODE;
                    end
                end
            end
            fbs_pkg::FBS_DONE: begin
                // completion holds until the master lets go of request
                if (!instr_exec_request) begin
                    next_r.done = 1'b0;
                    next_r.st = fbs_pkg::FBS_IDLE;
                end
            end
        endcase

        // dedicated error reset is honoured only while faulted
        if (err_rst_rise && drive_fault) begin
            next_r.drv_reset = 1'b1;
        end

        // panel commands are ignored under fieldbus control
        next_r.run_cmd = net_mode ? link_run_cmd : panel_run_cmd;

        // millisecond tick from the system clock
        if (r.div == 17'(MS_CYCLES - 1)) begin
            next_r.div = 17'h00000;
            next_r.ms = 1'b1;
        end else begin
            next_r.div = r.div + 17'h00001;
        end

        // silence timer: in network mode, exchange stopping for any cause trips the drive
        if (!net_mode || link_exchange) begin
            next_r.silent_ms = 16'h0000;
        end else if (r.ms && r.silent_ms != 16'hFFFF) begin
            next_r.silent_ms = r.silent_ms + 16'h0001;
        end
        // a trip in the same cycle as a reset wins, so no trip is lost
        if (net_mode && r.silent_ms > comm_error_wait_time) begin
            next_r.fault = 1'b1;
        end else if (r.drv_reset) begin
            next_r.fault = 1'b0;
        end

        // link-run lamp follows good refreshes with a dropout time
        if (refresh_ok) begin
            next_r.lamp_ms = 16'h0000;
            next_r.lrun = 1'b1;
        end else begin
            if (r.ms && r.lamp_ms != fbs_pkg::LAMP_TIMEOUT_MS) begin
                next_r.lamp_ms = r.lamp_ms + 16'h0001;
            end
            if (r.lamp_ms == fbs_pkg::LAMP_TIMEOUT_MS) begin
                next_r.lrun = 1'b0;
            end
        end

        // shared flash rate for the lamps
        if (r.ms) begin
            if (r.blink_ms == fbs_pkg::BLINK_HALF_MS - 8'h01) begin
                next_r.blink_ms = 8'h00;
                next_r.blink = !r.blink;
            end else begin
                next_r.blink_ms = r.blink_ms + 8'h01;
            end
        end

        // settings are caught after release of reset and at each reset
        if (!r.loaded || r.drv_reset) begin
            next_r.station = station_number_setting;
            next_r.baud = baud_rate_setting;
            next_r.loaded = 1'b1;
        end

        // status lamps
        next_r.lerr = pending ? r.blink : local_comm_error;
        next_r.run_l = master_ver1 ? r.blink : 1'b1;
        next_r.sd = tx_active;
        // carrier pin is asynchronous, so three stages before use
        next_r.rx_sync = {r.rx_sync[1:0], rx_carrier};
        if (r.rx_sync[1] == r.rx_sync[2]) begin
            next_r.rd = r.rx_sync[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign instr_exec_done = r.done;
    assign reply_code_word = r.reply;
    assign read_data_word = r.rdata;
    assign drive_reset = r.drv_reset;
    assign run_cmd = r.run_cmd;
    assign comm_loss_fault = r.fault;
    assign active_station = r.station;
    assign active_baud = r.baud;
    assign link_run_lamp = r.lrun;
    assign link_error_lamp = r.lerr;
    assign run_lamp = r.run_l;
    assign transmit_lamp = r.sd;
    assign receive_lamp = r.rd;

    // checks on the handshake, resets and lamps
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_complete;
        start |=> instr_exec_done && (r.st == fbs_pkg::FBS_DONE);
    endproperty
    a_complete: assert property (p_complete)
        else $error("completion not raised after start");

    property p_fault_read;
        start && instr_code_word == fbs_pkg::CODE_FAULT_READ |=>
            read_data_word == $past(hist)
            && reply_code_word == fbs_pkg::REPLY_OK;
    endproperty
    a_fault_read: assert property (p_fault_read)
        else $error("fault history read returned wrong data");

    property p_done_hold;
        instr_exec_done && instr_exec_request |=> instr_exec_done;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("completion dropped while request high");

    property p_done_clear;
        instr_exec_done && !instr_exec_request |=> !instr_exec_done;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("completion stuck after request low");

    property p_err_rst_ignored;
        err_rst_rise && !drive_fault && !start |=> !drive_reset;
    endproperty
    a_err_rst_ignored: assert property (p_err_rst_ignored)
        else $error("error reset acted without a fault");

    property p_link_reset;
        start && instr_code_word == fbs_pkg::CODE_LINK_RESET
            && write_data_word == fbs_pkg::RESET_KEY && link_reset_ok
            |=> drive_reset && reply_code_word == fbs_pkg::REPLY_OK;
    endproperty
    a_link_reset: assert property (p_link_reset)
        else $error("keyed link reset not performed");

    property p_bad_code;
        start && instr_code_word != fbs_pkg::CODE_FAULT_READ
            && instr_code_word != fbs_pkg::CODE_LINK_RESET
            |=> reply_code_word != fbs_pkg::REPLY_OK;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("unknown code answered as normal");

    property p_panel_ignored;
        net_mode |=> run_cmd == $past(link_run_cmd);
    endproperty
    a_panel_ignored: assert property (p_panel_ignored)
        else $error("run command not from master in network mode");

    property p_comm_loss;
        $rose(comm_loss_fault) |->
            $past(net_mode) && $past(r.silent_ms) > $past(comm_error_wait_time);
    endproperty
    a_comm_loss: assert property (p_comm_loss)
        else $error("comm loss tripped without silence");

    property p_lrun;
        refresh_ok |=> link_run_lamp;
    endproperty
    a_lrun: assert property (p_lrun)
        else $error("link-run lamp not lit on refresh");

    property p_sd;
        !tx_active |=> !transmit_lamp;
    endproperty
    a_sd: assert property (p_sd)
        else $error("transmit lamp on while idle");

    property p_rd;
        r.rx_sync[1] == r.rx_sync[2] |=> receive_lamp == $past(r.rx_sync[2]);
    endproperty
    a_rd: assert property (p_rd)
        else $error("receive lamp does not follow carrier");

    c_fault_read: cover property (start
        && instr_code_word == fbs_pkg::CODE_FAULT_READ ##1 instr_exec_done);
    c_link_reset: cover property (start ##1 drive_reset);
    c_comm_loss: cover property ($rose(comm_loss_fault));
    c_err_reset: cover property (err_rst_rise && drive_fault ##1 drive_reset);

endmodule
`default_nettype wire

// >>> rtl/fbs_pkg.sv
// fbs_pkg: constants and types shared by the fieldbus slave handshake block
// assumes a 100 MHz system clock and 16-bit remote register words
package fbs_pkg;

    // system clock and millisecond tick
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

    // instruction codes and key values
    localparam logic [15:0] CODE_FAULT_READ = 16'h0074;
    localparam logic [15:0] CODE_LINK_RESET = 16'h00FD;
    localparam logic [15:0] RESET_KEY = 16'h9696;
    localparam logic [15:0] COMM_RESET_ANY_MODE = 16'h0000;

    // reply codes: zero is a normal completion
    localparam logic [15:0] REPLY_OK = 16'h0000;
    localparam logic [15:0] REPLY_BAD_CODE = 16'h0001;
    localparam logic [15:0] REPLY_BAD_DATA = 16'h0003;

    // lamp timing in milliseconds
    localparam logic [15:0] LAMP_TIMEOUT_MS = 16'h0064;
    localparam logic [7:0] BLINK_HALF_MS = 8'hFA;

    // values after reset
    localparam logic [15:0] HIST_RESET = 16'h0000;
    localparam logic [7:0] FAULT_CODE_RESET = 8'h00;

    typedef enum logic [0:0] {
        FBS_IDLE,
        FBS_DONE
    } fbs_state_t;

endpackage

// >>> rtl/fbs_fault_hist.sv
// fbs_fault_hist: remembers the two most recent drive fault codes
// assumes fault_push is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module fbs_fault_hist (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fault_push,
    input wire logic [7:0] fault_code,
    output logic [15:0] hist
);

    typedef struct packed {
        logic [7:0] newest;
        logic [7:0] prior;
    } fbs_hist_t;

    fbs_hist_t r;
    fbs_hist_t next_r;

    // shift the newest record down when a new fault arrives
    always_comb begin
        next_r = r;
        if (fault_push) begin
            next_r.prior = r.newest;
            next_r.newest = fault_code;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= fbs_pkg::HIST_RESET;
        end else begin
            r <= next_r;
        end
    end

    // newest record in the low byte, older one above it
    assign hist = {r.prior, r.newest};

endmodule
`default_nettype wire

// >>> verif/fbs_master_model.sv
// fbs_master_model: behavioural fieldbus master driving the handshake
// assumes the bench calls xfer and toggles alive to stop the exchange
`timescale 1ns/1ps
`default_nettype none
module fbs_master_model (
    input wire logic clk,
    input wire logic instr_exec_done,
    input wire logic [15:0] reply_code_word,
    input wire logic [15:0] read_data_word,
    output logic instr_exec_request,
    output logic [15:0] instr_code_word,
    output logic [15:0] write_data_word,
    output logic link_exchange
);
    int to = 0;
    logic alive = 1'b1;
    // exchange stops when the master is off or reset
    assign link_exchange = alive;
    initial begin
        instr_exec_request = 1'b0;
        instr_code_word = 16'h0000;
        write_data_word = 16'h0000;
    end
    // one instruction; hold keeps the request up past completion
    task automatic xfer(input logic [15:0] code, wd, input int hold,
                        output logic [15:0] rep, rd, output int dn);
        int i;
        dn = 0;
        instr_code_word = code;
        write_data_word = wd;
        @(posedge clk);
        #1;
        instr_exec_request = 1'b1;
        for (i = 0; i < 20 && instr_exec_done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 20) to++;
        // words go stale once taken, so show something else
        instr_code_word = ~code;
        write_data_word = ~wd;
        for (i = 0; i < hold; i++) begin
            @(posedge clk);
            #1;
            if (instr_exec_done === 1'b1) dn++;
        end
        rep = reply_code_word;
        rd = read_data_word;
        instr_exec_request = 1'b0;
        for (i = 0; i < 8 && instr_exec_done !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 8) to++;
    endtask
endmodule
`default_nettype wire

// >>> verif/fbs_top_bench.sv
// fbs_top_bench: directed checks of the fieldbus slave handshake block
// assumes a shortened ms tick of 10 cycles; master is fbs_master_model
`timescale 1ns/1ps
`default_nettype none
module fbs_top_bench;
    logic clk, rstn, error_reset_request, drive_fault, fault_event;
    logic net_mode, refresh_ok, local_comm_error, master_ver1;
    logic tx_active, rx_carrier, link_exchange, instr_exec_request;
    logic instr_exec_done, drive_reset, comm_loss_fault, link_run_lamp;
    logic link_error_lamp, run_lamp, transmit_lamp, receive_lamp;
    logic [15:0] instr_code_word, write_data_word, reply_code_word;
    logic [15:0] read_data_word, comm_reset_select, comm_error_wait_time;
    logic [7:0] fault_code, station_number_setting, active_station;
    logic [2:0] baud_rate_setting, active_baud;
    logic [1:0] link_run_cmd, panel_run_cmd, run_cmd;
    logic [15:0] rep, rd;
    logic le, rl;
    int dn, nrs = 0, n0, te, tr, mismatches = 0, tests_run = 0;

    fbs_top #(.MS_CYCLES(10)) u_dut (.clk, .rstn, .instr_exec_request,
        .instr_code_word, .write_data_word, .error_reset_request,
        .drive_fault, .fault_event, .fault_code, .net_mode,
        .comm_reset_select, .comm_error_wait_time, .link_exchange,
        .refresh_ok, .local_comm_error, .station_number_setting,
        .baud_rate_setting, .master_ver1, .tx_active, .rx_carrier,
        .link_run_cmd, .panel_run_cmd, .instr_exec_done, .reply_code_word,
        .read_data_word, .drive_reset, .run_cmd, .comm_loss_fault,
        .active_station, .active_baud, .link_run_lamp, .link_error_lamp,
        .run_lamp, .transmit_lamp, .receive_lamp);
    fbs_master_model u_mst (.clk, .instr_exec_done, .reply_code_word,
        .read_data_word, .instr_exec_request, .instr_code_word,
        .write_data_word, .link_exchange);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count reset pulses on the falling edge, where the pulse is settled
    always @(negedge clk) begin
        if (drive_reset === 1'b1) nrs++;
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        test_done();
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [15:0] code, wd, input int hold);
        u_mst.xfer(code, wd, hold, rep, rd, dn);
    endtask
    // link reset attempt; ok says whether it must be accepted
    task automatic lrst(input logic nm, input logic [15:0] sel, key,
                        input logic ok);
        net_mode = nm;
        comm_reset_select = sel;
        n0 = nrs;
        run(fbs_pkg::CODE_LINK_RESET, key, 0);
        chk(rep, ok ? fbs_pkg::REPLY_OK : fbs_pkg::REPLY_BAD_DATA);
        chk(16'(nrs - n0), {15'h0000, ok});
    endtask
    task automatic test_done;
        mismatches += u_mst.to;
        $display("compared %0d, mismatched %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        {rstn, error_reset_request, drive_fault, fault_event} = 4'h0;
        {net_mode, refresh_ok, local_comm_error, master_ver1} = 4'h0;
        {tx_active, rx_carrier} = 2'h0;
        comm_reset_select = 16'h0001;
        comm_error_wait_time = 16'h0002;
        fault_code = 8'h00;
        station_number_setting = 8'h01;
        baud_rate_setting = 3'h1;
        link_run_cmd = 2'h1;
        panel_run_cmd = 2'h2;
        tk(16);
        rstn = 1'b1;
        tk(2);
        chk(run_lamp, 16'h0001);
        chk(active_station, 16'h0001);
        $display("test reset done");
        // two faults, newest lands in the low byte
        fault_code = 8'h12;
        fault_event = 1'b1;
        tk(1);
        fault_code = 8'h34;
        tk(1);
        fault_event = 1'b0;
        run(fbs_pkg::CODE_FAULT_READ, 16'h0000, 0);
        chk(rep, fbs_pkg::REPLY_OK);
        chk(rd, 16'h1234);
        run(16'h0055, 16'h0000, 4);
        chk(rep, fbs_pkg::REPLY_BAD_CODE);
        chk(dn[15:0], 16'h0004);
        $display("test handshake done");
        // new settings wait for a reset; lamps flash meanwhile
        station_number_setting = 8'h05;
        baud_rate_setting = 3'h2;
        master_ver1 = 1'b1;
        tk(3);
        chk(active_station, 16'h0001);
        chk(16'(active_baud), 16'h0001);
        {le, rl, te, tr} = {link_error_lamp, run_lamp, 64'h0};
        repeat (6000) begin
            tk(1);
            if (link_error_lamp !== le) te++;
            if (run_lamp !== rl) tr++;
            {le, rl} = {link_error_lamp, run_lamp};
        end
        chk(16'(te >= 2), 16'h0001);
        chk(16'(tr >= 2), 16'h0001);
        master_ver1 = 1'b0;
        lrst(1'b0, 16'h0001, fbs_pkg::RESET_KEY, 1'b0);
        lrst(1'b0, 16'h0000, fbs_pkg::RESET_KEY, 1'b1);
        lrst(1'b1, 16'h0001, 16'h1234, 1'b0);
        lrst(1'b1, 16'h0001, fbs_pkg::RESET_KEY, 1'b1);
        tk(2);
        chk(active_station, 16'h0005);
        chk(16'(active_baud), 16'h0002);
        $display("test link reset done");
        // error reset only counts with a fault present
        n0 = nrs;
        error_reset_request = 1'b1;
        tk(3);
        error_reset_request = 1'b0;
        drive_fault = 1'b1;
        tk(2);
        chk(16'(nrs - n0), 16'h0000);
        error_reset_request = 1'b1;
        tk(3);
        error_reset_request = 1'b0;
        drive_fault = 1'b0;
        chk(16'(nrs - n0), 16'h0001);
        chk(run_cmd, 16'h0001);
        $display("test error reset done");
        // master goes silent in network mode, then again outside it
        u_mst.alive = 1'b0;
        tk(15);
        chk(comm_loss_fault, 16'h0000);
        tk(60);
        chk(comm_loss_fault, 16'h0001);
        u_mst.alive = 1'b1;
        tk(50);
        chk(comm_loss_fault, 16'h0001);
        lrst(1'b1, 16'h0001, fbs_pkg::RESET_KEY, 1'b1);
        tk(2);
        chk(comm_loss_fault, 16'h0000);
        net_mode = 1'b0;
        u_mst.alive = 1'b0;
        tk(80);
        chk(comm_loss_fault, 16'h0000);
        chk(16'(run_cmd), 16'h0002);
        u_mst.alive = 1'b1;
        $display("test comm loss done");
        // indicator lamps
        tx_active = 1'b1;
        rx_carrier = 1'b1;
        local_comm_error = 1'b1;
        refresh_ok = 1'b1;
        tk(1);
        refresh_ok = 1'b0;
        tk(6);
        chk(transmit_lamp, 16'h0001);
        chk(receive_lamp, 16'h0001);
        chk(link_error_lamp, 16'h0001);
        chk(link_run_lamp, 16'h0001);
        {tx_active, rx_carrier, local_comm_error} = 3'h0;
        tk(6);
        chk(transmit_lamp, 16'h0000);
        chk(receive_lamp, 16'h0000);
        chk(link_error_lamp, 16'h0000);
        tk(500);
        chk(link_run_lamp, 16'h0001);
        tk(700);
        chk(link_run_lamp, 16'h0000);
        $display("test lamps done");
        test_done();
    end
endmodule
`default_nettype wire
